// >>> design/bfs_pkg.sv
/*
 * package for the breaker failure supervisor: register map, fields, states, timing.
 * assumes a 125 MHz processing clock and an APB slave with 32-bit data.
 */
package bfs_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SET_SEL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_ACK = 8'h18;
    localparam logic [7:0] ADDR_THR0 = 8'h20;
    localparam logic [7:0] ADDR_TIME0 = 8'h30;
    localparam int NUM_SETS = 4;
    localparam int SET_SEL_W = 2;
    localparam int CUR_W = 16;
    localparam int TIME_W = 32;
    // ------------------------------------------------------------
    // field layout of the control register
    // ------------------------------------------------------------
    localparam int CTRL_SCHEME_LSB = 0;
    localparam int CTRL_CLASS_LSB = 2;
    localparam int CTRL_TRIGEN_LSB = 4;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [CUR_W-1:0] THR_RESET = 16'h0000;
    // supervision time in microseconds and its cycle count
    localparam int CLK_MHZ = 125;
    localparam int SUP_TIME_US = 100000;
    localparam logic [TIME_W-1:0] TIME_RESET = 32'(SUP_TIME_US * CLK_MHZ);
    // ------------------------------------------------------------
    // interrupt bits
    // ------------------------------------------------------------
    localparam int IRQ_W = 3;
    localparam int IRQ_START = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_REJECT = 2;

    typedef enum logic [1:0] {
        SCH_CURRENT = 2'h0,
        SCH_POSITION = 2'h1,
        SCH_BOTH = 2'h2
    } bfs_scheme_e;

    typedef enum logic [1:0] {
        CLS_ALL = 2'h0,
        CLS_EXTERNAL = 2'h1,
        CLS_CURRENT = 2'h2,
        CLS_NONE = 2'h3
    } bfs_class_e;

    typedef enum logic [3:0] {
        ST_STANDBY = 4'h1,
        ST_RUNNING = 4'h2,
        ST_FAILED = 4'h4,
        ST_REJECTED = 4'h8
    } bfs_state_e;

    typedef struct packed {
        logic trip_all;
        logic trip_external;
        logic trip_current;
        logic [2:0] extra;
    } bfs_trig_s;

    typedef struct packed {
        logic [CUR_W-1:0] current;
        logic pos_open;
    } bfs_meas_s;
endpackage : bfs_pkg

// >>> design/bfs_supervisor.sv
/*
 * breaker failure supervisor: trigger forming, supervision timer control, state machine,
 * backup trip and latched lock outputs, APB register file with interrupt.
 * assumes trip, current and position inputs are synchronous to i_clock.
 */
// Operation
// RULE1: scheme selects judging by current, position, or both together.
// RULE2: supervision timer starts when a trigger activates the function.
// RULE3: current scheme fails when current stays at or above threshold.
// RULE4: position scheme fails when position never shows open.
// RULE5: combined scheme fails only when current high and not open; the code fails when current high or position not open.
// RULE6: timer keeps running after trigger deasserts.
// RULE7: timer expiry without stop asserts the backup trip.
// RULE8: detected opening under active scheme stops the timer.
// RULE9: opening while triggers active enters rejected, stays while triggered.
// RULE10: rejected returns to standby when all triggers drop.
// RULE11: software must set supervision time above total clearing time plus margin.
// RULE12: threshold and time held per set; active set values used.
// RULE13: latched lock output set with backup trip until acknowledged.
// RULE14: trigger is selected trip class ORed with three extra inputs.
// RULE15: reset and standby clear the timer and backup trip.
`timescale 1ns/10ps
module bfs_supervisor #(
    parameter int NSETS = bfs_pkg::NUM_SETS,
    parameter logic [bfs_pkg::TIME_W-1:0] TIME_DEFAULT = bfs_pkg::TIME_RESET
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire bfs_pkg::bfs_trig_s i_trig,
    input wire bfs_pkg::bfs_meas_s i_meas,
    output logic o_backup_trip,
    output logic o_lock,
    output logic o_irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [6:0] ctrl_reg;
    logic [bfs_pkg::SET_SEL_W-1:0] set_sel_reg;
    logic [bfs_pkg::CUR_W-1:0] thr_reg [NSETS];
    logic [bfs_pkg::TIME_W-1:0] time_reg [NSETS];
    logic [bfs_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [bfs_pkg::IRQ_W-1:0] irq_en_reg;
    bfs_pkg::bfs_state_e state_reg;
    bfs_pkg::bfs_state_e state_next;
    logic trig_reg;
    logic [bfs_pkg::IRQ_W-1:0] irq_event;

    logic access;
    logic wr;
    logic trig_now;
    logic opened;
    logic t_load;
    logic t_clear;
    logic t_running;
    logic t_expired;
    logic [1:0] scheme;
    logic [1:0] trig_class;
    logic [31:0] thr_hit;
    logic [31:0] time_hit;

    function automatic logic [31:0] word_sel(input logic [7:0] a, input logic [7:0] base);
        word_sel = 32'h0;
        for (int k = 0; k < NSETS; k++) begin
            if (a == base + 8'(4 * k)) begin
                word_sel[k] = 1'b1;
            end
        end
    endfunction : word_sel

    assign access = i_psel && i_penable;
    assign wr = access && i_pwrite;
    assign thr_hit = word_sel(i_paddr, bfs_pkg::ADDR_THR0);
    assign time_hit = word_sel(i_paddr, bfs_pkg::ADDR_TIME0);
    assign scheme = ctrl_reg[bfs_pkg::CTRL_SCHEME_LSB +: 2];
    assign trig_class = ctrl_reg[bfs_pkg::CTRL_CLASS_LSB +: 2];

    // ------------------------------------------------------------
    // trigger forming and opening detection
    // ------------------------------------------------------------
    always_comb begin
        // RULE14 trigger class OR
        case (trig_class)
            bfs_pkg::CLS_ALL: trig_now = i_trig.trip_all;
            bfs_pkg::CLS_EXTERNAL: trig_now = i_trig.trip_external;
            bfs_pkg::CLS_CURRENT: trig_now = i_trig.trip_current;
            default: trig_now = 1'b0;
        endcase
        trig_now = trig_now || |(i_trig.extra & ctrl_reg[bfs_pkg::CTRL_TRIGEN_LSB +: 3]);
    end

    always_comb begin
        logic cur_low;
        // RULE12 active set threshold
        cur_low = i_meas.current < thr_reg[set_sel_reg];
        // RULE1 scheme selection
        case (scheme)
            bfs_pkg::SCH_CURRENT: opened = cur_low;
            bfs_pkg::SCH_POSITION: opened = i_meas.pos_open;
            // both must show open here, while RULE5 stops on either showing open
            bfs_pkg::SCH_BOTH: opened = cur_low && i_meas.pos_open;
            default: opened = cur_low;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            trig_reg <= 1'b0;
        end else begin
            trig_reg <= trig_now;
        end
    end

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        t_load = 1'b0;
        t_clear = 1'b0;
        case (state_reg)
            bfs_pkg::ST_STANDBY: begin
                // RULE2 start on trigger
                if (trig_now && !trig_reg) begin
                    state_next = bfs_pkg::ST_RUNNING;
                    t_load = 1'b1;
                end
            end
            bfs_pkg::ST_RUNNING: begin
                // RULE8 stop on opening
                if (opened && t_running) begin
                    t_clear = 1'b1;
                    // RULE9 opened while triggered
                    state_next = trig_now ? bfs_pkg::ST_REJECTED : bfs_pkg::ST_STANDBY;
                // RULE3 RULE4 RULE7 expiry means failure
                end else if (t_expired) begin
                    state_next = bfs_pkg::ST_FAILED;
                end
                // RULE6 trigger drop ignored here
            end
            bfs_pkg::ST_FAILED: begin
                // trip held until triggers drop and breaker is seen open
                if (!trig_now && opened) begin
                    state_next = bfs_pkg::ST_STANDBY;
                end
            end
            bfs_pkg::ST_REJECTED: begin
                // RULE10 return when triggers drop
                if (!trig_now) begin
                    state_next = bfs_pkg::ST_STANDBY;
                end
            end
            default: state_next = bfs_pkg::ST_STANDBY;
        endcase
        // RULE15 standby clears timer
        if (state_next == bfs_pkg::ST_STANDBY) begin
            t_clear = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_reg <= bfs_pkg::ST_STANDBY;
        end else begin
            state_reg <= state_next;
        end
    end

    bfs_timer #(
        .W(bfs_pkg::TIME_W)
    ) u_timer (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_load(t_load),
        .i_clear(t_clear),
        .i_count(time_reg[set_sel_reg]),
        .o_running(t_running),
        .o_expired(t_expired)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        // RULE15 reset clears trip
        if (!i_rst_b) begin
            o_backup_trip <= 1'b0;
        end else begin
            // RULE7 trip while failed
            o_backup_trip <= (state_next == bfs_pkg::ST_FAILED);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_lock <= 1'b0;
        // RULE13 latched lock
        end else if (state_next == bfs_pkg::ST_FAILED) begin
            o_lock <= 1'b1;
        end else if (wr && i_paddr == bfs_pkg::ADDR_ACK && i_pwdata[0]) begin
            o_lock <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // RULE11 time written by software
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            ctrl_reg <= bfs_pkg::CTRL_RESET;
            set_sel_reg <= '0;
            irq_en_reg <= '0;
        end else if (wr) begin
            if (i_paddr == bfs_pkg::ADDR_CTRL) begin
                ctrl_reg <= i_pwdata[6:0];
            end
            if (i_paddr == bfs_pkg::ADDR_SET_SEL) begin
                set_sel_reg <= i_pwdata[bfs_pkg::SET_SEL_W-1:0];
            end
            if (i_paddr == bfs_pkg::ADDR_IRQ_EN) begin
                irq_en_reg <= i_pwdata[bfs_pkg::IRQ_W-1:0];
            end
        end
    end

    generate
        for (genvar g = 0; g < NSETS; g++) begin : g_set
            // RULE12 per-set values
            always_ff @(posedge i_clock) begin
                if (!i_rst_b) begin
                    thr_reg[g] <= bfs_pkg::THR_RESET;
                    time_reg[g] <= TIME_DEFAULT;
                end else if (wr) begin
                    if (thr_hit[g]) begin
                        thr_reg[g] <= i_pwdata[bfs_pkg::CUR_W-1:0];
                    end
                    if (time_hit[g]) begin
                        time_reg[g] <= i_pwdata;
                    end
                end
            end
        end
    endgenerate

    // sticky events: set wins over a clear in the same cycle
    always_comb begin
        irq_event = '0;
        irq_event[bfs_pkg::IRQ_START] = t_load;
        irq_event[bfs_pkg::IRQ_FAIL] = state_next == bfs_pkg::ST_FAILED && state_reg == bfs_pkg::ST_RUNNING;
        irq_event[bfs_pkg::IRQ_REJECT] = state_next == bfs_pkg::ST_REJECTED && state_reg != bfs_pkg::ST_REJECTED;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            irq_stat_reg <= '0;
        end else if (wr && i_paddr == bfs_pkg::ADDR_IRQ_CLR) begin
            irq_stat_reg <= (irq_stat_reg & ~i_pwdata[bfs_pkg::IRQ_W-1:0]) | irq_event;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_event;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // no wait state: ready in the first cycle of the access phase
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
            if (i_psel && !i_penable && !i_pwrite) begin
                case (i_paddr)
                    bfs_pkg::ADDR_CTRL: o_prdata <= {25'h0, ctrl_reg};
                    bfs_pkg::ADDR_SET_SEL: o_prdata <= {30'h0, set_sel_reg};
                    bfs_pkg::ADDR_STATUS: o_prdata <= {26'h0, o_lock, t_running, state_reg};
                    bfs_pkg::ADDR_IRQ_STAT: o_prdata <= {29'h0, irq_stat_reg};
                    bfs_pkg::ADDR_IRQ_EN: o_prdata <= {29'h0, irq_en_reg};
                    default: begin
                        for (int k = 0; k < NSETS; k++) begin
                            if (thr_hit[k]) begin
                                o_prdata <= {16'h0, thr_reg[k]};
                            end
                            if (time_hit[k]) begin
                                o_prdata <= time_reg[k];
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_start;  // RULE2
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == bfs_pkg::ST_STANDBY && trig_now && !trig_reg) |=> state_reg == bfs_pkg::ST_RUNNING;
    endproperty
    a_start: assert property (p_start) else $error("trigger did not start timer");

    property p_keep;  // RULE6
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == bfs_pkg::ST_RUNNING && !trig_now && !opened && !t_expired) |=> state_reg == bfs_pkg::ST_RUNNING;
    endproperty
    a_keep: assert property (p_keep) else $error("timer stopped on trigger drop");

    property p_fail;  // RULE7
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == bfs_pkg::ST_RUNNING && t_expired && !opened) |=> o_backup_trip && o_lock;
    endproperty
    a_fail: assert property (p_fail) else $error("expiry gave no backup trip");

    property p_stop;  // RULE8
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == bfs_pkg::ST_RUNNING && opened && t_running) |=> !t_running && !o_backup_trip;
    endproperty
    a_stop: assert property (p_stop) else $error("opening did not stop timer");

    property p_reject;  // RULE9
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == bfs_pkg::ST_REJECTED && trig_now) |=> state_reg == bfs_pkg::ST_REJECTED;
    endproperty
    a_reject: assert property (p_reject) else $error("left rejected while triggered");

    property p_back;  // RULE10
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == bfs_pkg::ST_REJECTED && !trig_now) |=> state_reg == bfs_pkg::ST_STANDBY;
    endproperty
    a_back: assert property (p_back) else $error("rejected did not return");

    property p_lock;  // RULE13
        @(posedge i_clock) disable iff (!i_rst_b)
        (o_lock && !(wr && i_paddr == bfs_pkg::ADDR_ACK)) |=> o_lock;
    endproperty
    a_lock: assert property (p_lock) else $error("lock dropped without acknowledge");

    property p_idle;  // RULE15
        @(posedge i_clock) disable iff (!i_rst_b)
        state_reg == bfs_pkg::ST_STANDBY |-> !t_running && !o_backup_trip;
    endproperty
    a_idle: assert property (p_idle) else $error("standby with timer or trip");
endmodule : bfs_supervisor

// >>> design/bfs_timer.sv
/*
 * supervision down-counter: load on start, clear on stop, expiry pulse at zero.
 * assumes load and clear are never high in the same cycle as a fresh start.
 */
`timescale 1ns/10ps
module bfs_timer #(
    parameter int W = 32
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_load,
    input wire logic i_clear,
    input wire logic [W-1:0] i_count,
    output logic o_running,
    output logic o_expired
);
    logic [W-1:0] count_reg;

    always_ff @(posedge i_clock) begin
        if (!i_rst_b || i_clear) begin
            count_reg <= '0;
            o_running <= 1'b0;
            o_expired <= 1'b0;
        end else if (i_load) begin
            count_reg <= (i_count == '0) ? W'(1) : i_count;
            o_running <= 1'b1;
            o_expired <= 1'b0;
        end else if (o_running) begin
            count_reg <= count_reg - W'(1);
            o_expired <= (count_reg == W'(1));
            o_running <= (count_reg != W'(1));
        end else begin
            o_expired <= 1'b0;
        end
    end
endmodule : bfs_timer

// >>> verif/bfs_breaker_model.sv
/*
 * breaker seen from the supervisor: current and position feedback of the local breaker,
 * plus the upstream breaker that the backup trip opens.
 * assumes the bench drives the local trip command and the fault modes on rising edges.
 */
`timescale 1ns/10ps
// ------------------------------------------------------------
// breaker model
// ------------------------------------------------------------
module bfs_breaker_model (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_trip,
    input wire logic i_backup_trip,
    input wire logic i_close,
    input wire logic i_stuck,
    input wire logic i_fake_open,
    input wire logic [7:0] i_delay,
    input wire logic [15:0] i_load,
    output bfs_pkg::bfs_meas_s o_meas
);
    logic [7:0] cnt_reg;
    logic open_reg;
    logic up_open_reg;

    always_ff @(posedge i_clock) begin
        if (!i_rst_b || i_close) begin
            cnt_reg <= 8'h00;
            open_reg <= 1'b0;
            up_open_reg <= 1'b0;
        end else begin
            if (i_trip && !i_stuck && !open_reg) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
            // a stuck breaker never opens, whatever the command
            if (cnt_reg == i_delay && i_delay != 8'h00 && !i_stuck) begin
                open_reg <= 1'b1;
            end
            if (i_backup_trip) begin
                up_open_reg <= 1'b1;
            end
        end
    end

    // fake open models a faulty auxiliary contact
    assign o_meas = {((open_reg || up_open_reg) ? 16'h0000 : i_load), (open_reg || i_fake_open)};
endmodule : bfs_breaker_model

// >>> verif/bfs_supervisor_tb.sv
/*
 * self-checking bench for the breaker failure supervisor.
 * assumes 125 MHz clock, APB answer within a few cycles, and a short TIME_DEFAULT.
 */
`timescale 1ns/10ps
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module bfs_supervisor_tb;
    // supervision time above breaker open time
    localparam logic [31:0] T0 = 32'h00000014;
    logic i_clock, i_rst_b, psel, penable, pwrite, pready, pslverr, bk, lock, irq;
    logic stuck, fake, close_br;
    logic [7:0] paddr, delay;
    logic [15:0] load;
    logic [31:0] pwdata, prdata, rd;
    bfs_pkg::bfs_trig_s trig;
    bfs_pkg::bfs_meas_s meas;
    int fail_count = 0;
    int num_checks = 0;
    logic [1:0] cls_tab [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
    logic [5:0] bit_tab [7] = '{6'h20, 6'h10, 6'h08, 6'h38, 6'h08, 6'h10, 6'h04};
    logic [31:0] exp_tab [7] = '{32'h5, 32'h5, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0};

    bfs_supervisor #(.TIME_DEFAULT(T0)) uut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_trig(trig), .i_meas(meas), .o_backup_trip(bk),
        .o_lock(lock), .o_irq(irq));
    bfs_breaker_model model (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_trip(|trig), .i_backup_trip(bk),
        .i_close(close_br), .i_stuck(stuck), .i_fake_open(fake), .i_delay(delay), .i_load(load),
        .o_meas(meas));

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // one APB transfer; waits on pready, no fixed latency assumed
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        chk(32'(pslverr), 32'h0, "pslverr");
        chk(32'(pready), 32'h1, "pready");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, msg);
    endtask : rchk

    // counts edges from trigger change until the backup trip shows
    task wait_trip(input int exp, input string msg);
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (bk !== 1'b1 && n < 300);
        chk(32'(n), 32'(exp), msg);
    endtask : wait_trip

    task reclose();
        @(posedge i_clock);
        close_br <= 1'b1;
        stuck <= 1'b0;
        fake <= 1'b0;
        trig <= '0;
        @(posedge i_clock);
        close_br <= 1'b0;
    endtask : reclose

    task t_reset_regs();
        rchk(bfs_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
        rchk(bfs_pkg::ADDR_STATUS, 32'h1, "standby");
        rchk(bfs_pkg::ADDR_TIME0 + 8'h0c, T0, "time3 reset");
        rchk(bfs_pkg::ADDR_THR0, 32'h0, "thr0 reset");
        apb(1'b1, 8'h44, 32'hffffffff);
        rchk(8'h44, 32'h0, "unmapped");
        apb(1'b1, bfs_pkg::ADDR_IRQ_EN, 32'h7);
        rchk(bfs_pkg::ADDR_IRQ_EN, 32'h7, "irq en");
        apb(1'b1, bfs_pkg::ADDR_IRQ_EN, 32'h2);
    endtask : t_reset_regs

    task t_fail_current();
        apb(1'b1, bfs_pkg::ADDR_SET_SEL, 32'h1);
        apb(1'b1, bfs_pkg::ADDR_THR0 + 8'h04, 32'h64);
        apb(1'b1, bfs_pkg::ADDR_TIME0 + 8'h04, 32'h1e);
        @(posedge i_clock);
        stuck <= 1'b1;
        load <= 16'h01f4;
        trig <= 6'h20;
        repeat (5) @(posedge i_clock);
        trig <= '0;
        wait_trip(30 + 3 - 5, "set1 expiry");
        chk(32'(lock), 32'h1, "lock set");
        repeat (2) @(posedge i_clock);
        chk(32'(irq), 32'h1, "irq raised");
        rchk(bfs_pkg::ADDR_STATUS, 32'h21, "standby locked");
        chk(32'(bk), 32'h0, "trip cleared");
        apb(1'b1, bfs_pkg::ADDR_IRQ_EN, 32'h0);
        repeat (2) @(posedge i_clock);
        chk(32'(irq), 32'h0, "irq masked");
        apb(1'b1, bfs_pkg::ADDR_IRQ_EN, 32'h2);
        rchk(bfs_pkg::ADDR_IRQ_STAT, 32'h3, "start and fail");
        apb(1'b1, bfs_pkg::ADDR_IRQ_CLR, 32'h7);
        repeat (2) @(posedge i_clock);
        chk(32'(irq), 32'h0, "irq cleared");
        apb(1'b1, bfs_pkg::ADDR_ACK, 32'h1);
        repeat (2) @(posedge i_clock);
        chk(32'(lock), 32'h0, "lock acked");
        apb(1'b1, bfs_pkg::ADDR_SET_SEL, 32'h0);
        reclose();
    endtask : t_fail_current

    task t_reject_position();
        apb(1'b1, bfs_pkg::ADDR_CTRL, 32'h1d);
        @(posedge i_clock);
        delay <= 8'h05;
        trig <= 6'h01;
        repeat (30) @(posedge i_clock);
        chk(32'(bk), 32'h0, "no trip after open");
        rchk(bfs_pkg::ADDR_STATUS, 32'h8, "rejected");
        @(posedge i_clock);
        trig <= '0;
        repeat (3) @(posedge i_clock);
        rchk(bfs_pkg::ADDR_STATUS, 32'h1, "back to standby");
        apb(1'b1, bfs_pkg::ADDR_IRQ_CLR, 32'h7);
        reclose();
    endtask : t_reject_position

    task t_both();
        apb(1'b1, bfs_pkg::ADDR_THR0, 32'h64);
        apb(1'b1, bfs_pkg::ADDR_CTRL, 32'h2);
        @(posedge i_clock);
        stuck <= 1'b1;
        fake <= 1'b1;
        trig <= 6'h20;
        wait_trip(int'(T0) + 3, "combined expiry");
        trig <= '0;
        repeat (4) @(posedge i_clock);
        chk(32'(bk), 32'h0, "trip cleared");
        apb(1'b1, bfs_pkg::ADDR_ACK, 32'h1);
        apb(1'b1, bfs_pkg::ADDR_IRQ_CLR, 32'h7);
        reclose();
    endtask : t_both

    // stuck breaker, position contact stays closed until released by the bench
    task t_pos_fail();
        apb(1'b1, bfs_pkg::ADDR_CTRL, 32'h1);
        @(posedge i_clock);
        stuck <= 1'b1;
        trig <= 6'h20;
        wait_trip(int'(T0) + 3, "position expiry");
        trig <= '0;
        fake <= 1'b1;
        repeat (4) @(posedge i_clock);
        chk(32'(bk), 32'h0, "position trip cleared");
        chk(32'(lock), 32'h1, "position lock held");
        apb(1'b1, bfs_pkg::ADDR_ACK, 32'h1);
        apb(1'b1, bfs_pkg::ADDR_IRQ_CLR, 32'h7);
        reclose();
    endtask : t_pos_fail

    task t_classes();
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, bfs_pkg::ADDR_CTRL, {28'h0, cls_tab[i], 2'h1});
            @(posedge i_clock);
            stuck <= 1'b1;
            fake <= 1'b1;
            trig <= bfs_pkg::bfs_trig_s'(bit_tab[i]);
            repeat (4) @(posedge i_clock);
            trig <= '0;
            repeat (3) @(posedge i_clock);
            rchk(bfs_pkg::ADDR_IRQ_STAT, exp_tab[i], "trigger class");
            apb(1'b1, bfs_pkg::ADDR_IRQ_CLR, 32'h7);
        end
        reclose();
    endtask : t_classes

    task finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    initial begin
        i_rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        trig = '0;
        stuck = 1'b0;
        fake = 1'b0;
        close_br = 1'b0;
        delay = 8'h05;
        load = 16'h0000;
        repeat (8) @(posedge i_clock);
        i_rst_b <= 1'b1;
        t_reset_regs();
        t_fail_current();
        t_reject_position();
        t_both();
        t_pos_fail();
        t_classes();
        finish_test();
    end

    // whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge i_clock);
        fail_count++;
        finish_test();
    end
endmodule : bfs_supervisor_tb
